// ==== dmd_mem_decode.v ====
`timescale 1ns/1ps
`include "dmd_consts.vh"

module dmd_mem_decode
(
   input  wire        clk,
   input  wire        rst,
   input  wire        ce,
   input  wire [1:0]  variant,
   // Internal data access
   input  wire        int_req,
   input  wire        int_we,
   input  wire        int_indirect,
   input  wire        int_stack,
   input  wire [7:0]  int_addr,
   input  wire [7:0]  int_wdata,
   // Special register access (direct only)
   input  wire        sfr_req,
   input  wire        sfr_we,
   input  wire [7:0]  sfr_addr,
   input  wire [7:0]  sfr_wdata,
   // External data move
   input  wire        xm_req,
   input  wire        xm_we,
   input  wire        xm_use_ptr,
   input  wire [7:0]  xm_index,
   input  wire [7:0]  xm_wdata,
   input  wire        xm_ptr_inc,
   // Code fetch / code move
   input  wire        code_req,
   input  wire        code_move,
   input  wire [15:0] code_addr,
   // Pins
   input  wire [7:0]  port0_in,
   output reg  [7:0]  rdata,
   output reg         rvalid,
   output reg         xm_busy,
   output reg  [15:0] code_addr_out,
   output reg         code_strobe,
   output reg  [7:0]  port0_out,
   output reg         port0_oe,
   output reg  [7:0]  port2_out,
   output reg         port2_oe,
   output reg         wr_n,
   output reg         rd_n,
   output reg         ale,
   output reg         onchip_xram_select,
   output reg         latch_strobe_off,
   output reg         pointer_select,
   output reg         user_flag_two
);

   // ===================================================================
   // Storage
   reg [7:0]  iram [0:255];
   reg [7:0]  xram [0:`DMD_XRAM_DEPTH-1];
   reg [7:0]  memctl_q;
   reg [7:0]  ptrctl_q;
   reg [15:0] first_pointer_q;
   reg [15:0] second_pointer_q;
   reg [7:0]  stack_pointer_q;
   reg [1:0]  st_q;
   reg [1:0]  ale_cnt_q;
   reg        xm_we_q;
   reg [15:0] xm_addr_q;
   reg [7:0]  xm_wdata_q;
   reg        xm_use_ptr_q;
   reg [7:0]  p0_s1_q;
   reg [7:0]  p0_s2_q;
   reg [1:0]  rd_wait_q;

   // ===================================================================
   // Decode
   wire [15:0] data_pointer = ptrctl_q[`DMD_BIT_PTR_SEL] ? second_pointer_q
                                                         : first_pointer_q;
   wire [15:0] xm_addr  = xm_use_ptr ? data_pointer : {8'h00, xm_index};
   reg  [15:0] xram_lim;
   always @*
   begin
      case (variant)
         2'h0:    xram_lim = `DMD_XRAM_LIM_V0;
         2'h1:    xram_lim = `DMD_XRAM_LIM_V1;
         default: xram_lim = `DMD_XRAM_LIM_V2;
      endcase
   end
   wire xm_onchip = memctl_q[`DMD_BIT_XRAM_SEL] &&
                    (!xm_use_ptr || (xm_addr < xram_lim));
   // Index moves are 8-bit, so they never exceed the smallest variant limit
   wire [7:0] iaddr = int_stack ? stack_pointer_q : int_addr;
   wire iaddr_ok = int_indirect || int_stack ||
                   !int_addr[`DMD_UPPER_BIT];

   reg [7:0] sfr_rd;
   always @*
   begin
      case (sfr_addr)
         `DMD_ADDR_MEMCTL: sfr_rd = memctl_q & `DMD_MEMCTL_MASK;
         `DMD_ADDR_PTRCTL: sfr_rd = ptrctl_q & `DMD_PTRCTL_MASK;
         `DMD_ADDR_PTR_LO: sfr_rd = data_pointer[7:0];
         `DMD_ADDR_PTR_HI: sfr_rd = data_pointer[15:8];
         `DMD_ADDR_STACK:  sfr_rd = stack_pointer_q;
         default:          sfr_rd = `DMD_RESET_BYTE;
      endcase
   end

   // ===================================================================
   // Registers and internal memories
   always @(posedge clk)
   begin
      if (rst)
      begin
         memctl_q         <= `DMD_RESET_BYTE;
         ptrctl_q         <= `DMD_RESET_BYTE;
         first_pointer_q  <= `DMD_RESET_WORD;
         second_pointer_q <= `DMD_RESET_WORD;
         stack_pointer_q  <= `DMD_RESET_BYTE;
         rdata            <= `DMD_RESET_BYTE;
         rvalid           <= 1'b0;
      end
      else if (ce)
      begin
         rvalid <= 1'b0;
         if (sfr_req && sfr_we)
         begin
            case (sfr_addr)
               `DMD_ADDR_MEMCTL: memctl_q <= sfr_wdata & `DMD_MEMCTL_MASK;
               `DMD_ADDR_PTRCTL: ptrctl_q <= sfr_wdata & `DMD_PTRCTL_MASK;
               `DMD_ADDR_PTR_LO:
               begin
                  if (ptrctl_q[`DMD_BIT_PTR_SEL])
                     second_pointer_q[7:0] <= sfr_wdata;
                  else
                     first_pointer_q[7:0] <= sfr_wdata;
               end
               `DMD_ADDR_PTR_HI:
               begin
                  if (ptrctl_q[`DMD_BIT_PTR_SEL])
                     second_pointer_q[15:8] <= sfr_wdata;
                  else
                     first_pointer_q[15:8] <= sfr_wdata;
               end
               `DMD_ADDR_STACK: stack_pointer_q <= sfr_wdata;
               default: ;
            endcase
         end
         else if (sfr_req)
         begin
            rdata  <= sfr_rd;
            rvalid <= 1'b1;
         end
         else if (xm_ptr_inc)
         begin
            if (ptrctl_q[`DMD_BIT_PTR_SEL])
               second_pointer_q <= second_pointer_q + 16'h0001;
            else
               first_pointer_q <= first_pointer_q + 16'h0001;
         end
         if (int_req && iaddr_ok)
         begin
            if (int_we)
               iram[iaddr] <= int_wdata;
            else
            begin
               rdata  <= iram[iaddr];
               rvalid <= 1'b1;
            end
         end
         if (xm_req && !xm_busy && xm_onchip)
         begin
            if (xm_we)
               xram[xm_addr[`DMD_XRAM_AW-1:0]] <= xm_wdata;
            else
            begin
               rdata  <= xram[xm_addr[`DMD_XRAM_AW-1:0]];
               rvalid <= 1'b1;
            end
         end
         if (rd_wait_q[1])
         begin
            rdata  <= p0_s2_q;
            rvalid <= 1'b1;
         end
      end
   end

   // ===================================================================
   // Control bit mirrors
   always @(posedge clk)
   begin
      if (rst)
      begin
         onchip_xram_select <= 1'b0;
         latch_strobe_off   <= 1'b0;
         pointer_select     <= 1'b0;
         user_flag_two      <= 1'b0;
      end
      else if (ce)
      begin
         onchip_xram_select <= memctl_q[`DMD_BIT_XRAM_SEL];
         latch_strobe_off   <= memctl_q[`DMD_BIT_LATCH_OFF];
         pointer_select     <= ptrctl_q[`DMD_BIT_PTR_SEL];
         user_flag_two      <= ptrctl_q[`DMD_BIT_USER_FLAG];
      end
   end

   // ===================================================================
   // Port 0 pin synchroniser
   always @(posedge clk)
   begin
      if (rst)
      begin
         p0_s1_q <= `DMD_RESET_BYTE;
         p0_s2_q <= `DMD_RESET_BYTE;
      end
      else if (ce)
      begin
         p0_s1_q <= port0_in;
         p0_s2_q <= p0_s1_q;
      end
   end

   // ===================================================================
   // Read return after the pin synchroniser
   // Pins are sampled while the read strobe is still low; the byte needs
   // two more cycles through the synchroniser before it is handed over
   always @(posedge clk)
   begin
      if (rst)
      begin
         rd_wait_q <= 2'h0;
      end
      else if (ce)
      begin
         rd_wait_q <= {rd_wait_q[0], (st_q == `DMD_ST_DONE) && !xm_we_q};
      end
   end

   // ===================================================================
   // External bus cycle
   always @(posedge clk)
   begin
      if (rst)
      begin
         st_q         <= `DMD_ST_IDLE;
         ale_cnt_q    <= 2'h0;
         xm_we_q      <= 1'b0;
         xm_addr_q    <= `DMD_RESET_WORD;
         xm_wdata_q   <= `DMD_RESET_BYTE;
         xm_use_ptr_q <= 1'b0;
         xm_busy      <= 1'b0;
         port0_out    <= `DMD_RESET_BYTE;
         port0_oe     <= 1'b0;
         port2_out    <= `DMD_RESET_BYTE;
         port2_oe     <= 1'b0;
         wr_n         <= 1'b1;
         rd_n         <= 1'b1;
         ale          <= 1'b0;
         code_addr_out <= `DMD_RESET_WORD;
         code_strobe  <= 1'b0;
      end
      else if (ce)
      begin
         code_strobe <= code_req;
         if (code_req)
            code_addr_out <= code_addr;
         ale_cnt_q <= ale_cnt_q + 2'h1;
         // Free-running latch strobe unless switched off
         if (!memctl_q[`DMD_BIT_LATCH_OFF])
            ale <= (ale_cnt_q == `DMD_ALE_DIV);
         else
            ale <= (st_q == `DMD_ST_ADDR) || (code_req && code_move);
         case (st_q)
            `DMD_ST_IDLE:
            begin
               if (xm_req && !xm_onchip)
               begin
                  st_q         <= `DMD_ST_ADDR;
                  xm_busy      <= 1'b1;
                  xm_we_q      <= xm_we;
                  xm_addr_q    <= xm_addr;
                  xm_wdata_q   <= xm_wdata;
                  xm_use_ptr_q <= xm_use_ptr;
               end
            end
            `DMD_ST_ADDR:
            begin
               port0_out <= xm_addr_q[7:0];
               port0_oe  <= 1'b1;
               if (xm_use_ptr_q)
               begin
                  port2_out <= xm_addr_q[15:8];
                  port2_oe  <= 1'b1;
               end
               st_q <= `DMD_ST_DATA;
            end
            `DMD_ST_DATA:
            begin
               if (xm_we_q)
               begin
                  port0_out <= xm_wdata_q;
                  wr_n      <= 1'b0;
               end
               else
               begin
                  port0_oe <= 1'b0;
                  rd_n     <= 1'b0;
               end
               st_q <= `DMD_ST_DONE;
            end
            `DMD_ST_DONE:
            begin
               wr_n     <= 1'b1;
               rd_n     <= 1'b1;
               port0_oe <= 1'b0;
               port2_oe <= 1'b0;
               xm_busy  <= 1'b0;
               st_q     <= `DMD_ST_IDLE;
            end
            default: st_q <= `DMD_ST_IDLE;
         endcase
      end
   end

endmodule

// ==== dmd_consts.vh ====
`ifndef DMD_CONSTS_VH
`define DMD_CONSTS_VH
// ======================================================================
// Special register addresses
`define DMD_ADDR_MEMCTL      8'h8E
`define DMD_ADDR_PTRCTL      8'hA2
`define DMD_ADDR_PTR_LO      8'h82
`define DMD_ADDR_PTR_HI      8'h83
`define DMD_ADDR_STACK       8'h81
// ======================================================================
// Field positions and reset values
`define DMD_BIT_LATCH_OFF    0
`define DMD_BIT_XRAM_SEL     1
`define DMD_BIT_PTR_SEL      0
`define DMD_BIT_USER_FLAG    3
`define DMD_MEMCTL_MASK      8'h03
`define DMD_PTRCTL_MASK      8'h09
`define DMD_RESET_BYTE       8'h00
`define DMD_RESET_WORD       16'h0000
`define DMD_UPPER_BIT        7
// ======================================================================
// Auxiliary RAM limits per variant (first address that goes off chip)
`define DMD_XRAM_LIM_V0      16'h0100
`define DMD_XRAM_LIM_V1      16'h0300
`define DMD_XRAM_LIM_V2      16'h0700
`define DMD_XRAM_DEPTH       1792
`define DMD_XRAM_AW          11
// ======================================================================
// External bus cycle phases
`define DMD_ST_IDLE          2'h0
`define DMD_ST_ADDR          2'h1
`define DMD_ST_DATA          2'h2
`define DMD_ST_DONE          2'h3
`define DMD_ALE_DIV          2'h1
`endif

// ==== dmd_mem_decode_props.sv ====
`timescale 1ns/1ps
module dmd_mem_decode_props
(
   input wire logic clk,
   input wire logic rst,
   input wire logic xm_req,
   input wire logic xm_use_ptr,
   input wire logic rvalid,
   input wire logic xm_busy,
   input wire logic port0_oe,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic ale,
   input wire logic code_strobe,
   input wire logic onchip_xram_select,
   input wire logic latch_strobe_off
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ======================================================================
   // Assertions
   strobe_excl_a: assert property (wr_n || rd_n)
      else $error("both strobes low");
   rd_answer_a: assert property ($fell(rd_n) |=> rd_n ##2 rvalid)
      else $error("read strobe not one cycle");
   wr_drive_a: assert property (!wr_n |-> port0_oe && xm_busy)
      else $error("write without bus drive");
   rd_float_a: assert property (!rd_n |-> !port0_oe && xm_busy)
      else $error("read while driving");
   busy_len_a: assert property ($rose(xm_busy) |-> xm_busy [*3] ##1 !xm_busy)
      else $error("bus cycle length");
   index_onchip_a: assert property (xm_req && !xm_busy && onchip_xram_select && !xm_use_ptr
      |=> (!xm_busy && !port0_oe) [*5])
      else $error("index move left chip");
   offchip_all_a: assert property (xm_req && !xm_busy && !onchip_xram_select
      |=> xm_busy ##2 !(rd_n && wr_n))
      else $error("move not external");
   ale_rate_a: assert property (ale && !latch_strobe_off |=> !ale [*3])
      else $error("latch strobe rate");
   ale_gate_a: assert property (ale && latch_strobe_off && $past(latch_strobe_off)
      |-> xm_busy || code_strobe)
      else $error("latch strobe while off");
   cover property ($fell(rd_n));
   cover property ($fell(wr_n));
   cover property (xm_req && onchip_xram_select);
   cover property (ale && latch_strobe_off && xm_busy);
endmodule

bind dmd_mem_decode dmd_mem_decode_props u_props (.*);

// ==== dmd_ext_mem_model.sv ====
`timescale 1ns/1ps
module dmd_ext_mem_model
(
   input  wire logic       clk,
   input  wire logic [7:0] port0_out,
   input  wire logic       port0_oe,
   input  wire logic [7:0] port2_out,
   input  wire logic       port2_oe,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   output logic      [7:0] port0_in
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr_q;
   logic [7:0]  pat_q = 8'h5A;
   // Memory drives only while the read strobe is low; released bus toggles
   assign port0_in = rd_n ? pat_q : mem[addr_q];
   always @(posedge clk)
   begin
      pat_q <= ~pat_q;
      if (port0_oe && wr_n && rd_n)
         addr_q <= {port2_oe ? port2_out : 8'h00, port0_out};
      if (!wr_n)
         mem[addr_q] <= port0_out;
   end
endmodule

// ==== data_memory_decode_dual_pointer_tb.sv ====
`timescale 1ns/1ps
module data_memory_decode_dual_pointer_tb;
   reg        clk, rst, ce, int_req, int_we, int_indirect, int_stack, sfr_req, sfr_we;
   reg        xm_req, xm_we, xm_use_ptr, xm_ptr_inc, code_req, code_move;
   reg [1:0]  variant;
   reg [7:0]  int_addr, int_wdata, sfr_addr, sfr_wdata, xm_index, xm_wdata, q, d, e;
   reg [15:0] code_addr, p0, p1;
   wire [7:0] port0_in, rdata, port0_out, port2_out;
   wire       rvalid, xm_busy, code_strobe, port0_oe, port2_oe, wr_n, rd_n, ale;
   wire       onchip_xram_select, latch_strobe_off, pointer_select, user_flag_two;
   wire [15:0] code_addr_out;
   int        error_cnt, checks, lim;
   bit        v, s;

   dmd_mem_decode dut (.*);
   dmd_ext_mem_model u_mem (.*);

   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run;
      if (error_cnt == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input [16:0] got, input [16:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Kind: 0 direct, 1 indirect, 2 special register, 3 index move, 4 pointer move
   task automatic op(input int k, input [7:0] a, input w, input [7:0] dat);
      @(posedge clk) #1;
      int_req = k < 2 || k == 5;
      int_stack = k == 5;
      xm_ptr_inc = k == 6;
      int_indirect = k == 1;
      sfr_req = k == 2;
      xm_req = k > 2;
      xm_use_ptr = k == 4;
      {int_we, sfr_we, xm_we} = {3{w}};
      {int_addr, sfr_addr, xm_index} = {3{a}};
      {int_wdata, sfr_wdata, xm_wdata} = {3{dat}};
      {v, s} = 2'b00;
      @(posedge clk) #1;
      {int_req, sfr_req, xm_req, xm_ptr_inc} = 4'h0;
      repeat (8)
      begin
         if (rvalid === 1'b1)
         begin
            v = 1;
            q = rdata;
         end
         if (wr_n !== 1'b1 || rd_n !== 1'b1 || port0_oe !== 1'b0)
            s = 1;
         @(posedge clk) #1;
      end
   endtask

   task automatic sp(input [15:0] p);
      op(2, 8'h82, 1, p[7:0]);
      op(2, 8'h83, 1, p[15:8]);
   endtask

   initial
   begin
      {int_req, int_we, int_indirect, int_stack, sfr_req, sfr_we, xm_req, xm_we} = 8'h00;
      {xm_use_ptr, xm_ptr_inc, code_req, code_move, variant} = 6'h00;
      {int_addr, int_wdata, sfr_addr, sfr_wdata, xm_index, xm_wdata, code_addr} = 64'h0;
      rst = 1;
      ce = 1;
      void'($urandom(99377));
      repeat (8) @(posedge clk);
      #1 rst = 0;
      op(2, 8'h8E, 0, 0);
      chk({v, q}, 9'h100);
      op(2, 8'hA2, 0, 0);
      chk({v, q}, 9'h100);
      code_req = 1;
      code_move = 1;
      code_addr = $urandom;
      @(posedge clk) #1;
      code_req = 0;
      chk({code_strobe, code_addr_out}, {1'b1, code_addr});
      op(2, 8'h8E, 1, 8'hFF);
      op(2, 8'h8E, 0, 0);
      chk({v, q}, 9'h103);
      op(2, 8'hA2, 1, 8'hFF);
      op(2, 8'hA2, 0, 0);
      chk({v, user_flag_two, q}, 10'h309);
      op(2, 8'hA2, 1, q + 8'h01);
      op(2, 8'hA2, 0, 0);
      chk({pointer_select, q}, 9'h008);
      for (int i = 0; i < 24; i++)
      begin
         e = $urandom;
         d = $urandom;
         op(e[7], e, 1, d);
         op(e[7], e, 0, 0);
         chk({v, q}, {1'b1, d});
         op(0, e | 8'h80, 0, 0);
         chk(v, 0);
      end
      op(1, 8'h8E, 1, 8'h55);
      op(2, 8'h8E, 0, 0);
      chk({v, q}, 9'h103);
      op(2, 8'h81, 1, 8'hC5);
      op(5, 0, 1, 8'h6B);
      op(1, 8'hC5, 0, 0);
      chk({v, q}, 9'h16B);
      p0 = $urandom;
      p1 = $urandom;
      op(2, 8'hA2, 1, 8'h00);
      sp(p0);
      op(2, 8'hA2, 1, 8'h01);
      sp(p1);
      for (int i = 0; i < 2; i++)
      begin
         op(2, 8'hA2, 1, 8'(i ^ 1));
         op(2, 8'h82, 0, 0);
         d = q;
         op(2, 8'h83, 0, 0);
         chk({pointer_select, q, d}, i ? {1'b0, p0} : {1'b1, p1});
      end
      op(6, 0, 0, 0);
      op(2, 8'h82, 0, 0);
      d = q;
      op(2, 8'h83, 0, 0);
      chk({q, d}, p0 + 16'h0001);
      ce = 0;
      op(2, 8'h8E, 1, 8'h00);
      ce = 1;
      op(2, 8'h8E, 0, 0);
      chk({v, q}, 9'h103);
      for (int i = 0; i < 4; i++)
      begin
         variant = i[1:0];
         lim = i == 0 ? 256 : i == 1 ? 768 : 1792;
         d = $urandom;
         op(2, 8'h8E, 1, 8'h03);
         sp(16'(lim - 1));
         op(4, 0, 1, d);
         op(4, 0, 0, 0);
         chk({v, s, q}, {2'b10, d});
         sp(16'(lim));
         op(4, 0, 1, ~d);
         op(4, 0, 0, 0);
         chk({v, s, q}, {2'b11, ~d});
         op(3, 8'h40 + 8'(i), 1, d + 8'h01);
         op(3, 8'h40 + 8'(i), 0, 0);
         chk({v, s, q}, {2'b10, d + 8'h01});
         op(2, 8'h8E, 1, 8'h00);
         sp(16'(lim - 1));
         op(4, 0, 1, d ^ 8'h3C);
         op(4, 0, 0, 0);
         chk({v, s, q}, {2'b11, d ^ 8'h3C});
         op(3, 8'h40 + 8'(i), 1, ~d);
         op(3, 8'h40 + 8'(i), 0, 0);
         chk({v, s, q}, {2'b11, ~d});
      end
      rst = 1;
      repeat (2) @(posedge clk);
      #1 rst = 0;
      op(2, 8'h8E, 0, 0);
      chk({v, q}, 9'h100);
      complete_run;
   end

   initial
   begin
      #500000;
      error_cnt++;
      complete_run;
   end
endmodule
